// ===== logic/cps_supervisor.sv
// The Wishbone register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "cps_defines.svh"
module cps_supervisor
    import cps_pkg::*;
#(
    parameter int DISCH_CYC = `CPS_DISCH_PULSE_MS * `CPS_CLK_KHZ,
    parameter int OC_DGL_CYC = `CPS_OC_DGL_MS * `CPS_CLK_KHZ,
    parameter int CHG_DGL_CYC = `CPS_CHG_DGL_US * `CPS_CLK_KHZ / 1000,
    parameter int OT_REL_CYC = `CPS_OT_REL_US * `CPS_CLK_KHZ / 1000
) (
    input wire logic sys_clk, // 25 MHz clock
    input wire logic sys_rst, // Synchronous reset, active high
    input wire logic wb_cyc_i, // Wishbone cycle
    input wire logic wb_stb_i, // Wishbone strobe
    input wire logic wb_we_i, // Wishbone write
    input wire logic [3:0] wb_adr_i, // Byte address
    input wire logic [3:0] wb_sel_i, // Byte lanes
    input wire logic [31:0] wb_dat_i, // Write data
    output logic [31:0] wb_dat_o, // Read data
    output logic wb_ack_o, // Acknowledge
    input wire logic enable_pin, // Enable pin, active high
    input wire logic [2:0] mode_select_pins, // Mode code
    input wire logic cur_above_th, // Switch current above charge level
    input wire logic oc_detect, // Current limit engaged
    input wire logic temp_above_trip, // Die above trip level
    input wire logic temp_cooled, // Die cooled below restart level
    input wire logic vin_above_input_undervoltage_lockout, // Input above lockout level
    input wire logic cdp_hs_done, // CDP handshake completed
    output logic discharge_on, // Output discharge active
    output logic power_switch_on, // Port power switch on
    output logic data_switch_on, // USB data switch on
    output logic emulation_on, // Charger profiles on
    output logic fault_n_o, // Fault pin level when driven
    output logic fault_n_oe, // Fault pin pulled low
    output logic charging_n_o, // Charging pin level when driven
    output logic charging_n_oe // Charging pin pulled low
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Remote-wakeup pairs keep the port powered across the change
    function automatic logic cps_wake_pair(input logic [2:0] a, input logic [2:0] b);
        logic x_side;
        x_side = (a[1:0] == 2'h2) || (a == `CPS_MODE_CDP);
        return (x_side && b == `CPS_MODE_CDP_WAKE) ||
            (a == `CPS_MODE_CDP_WAKE && ((b[1:0] == 2'h2) || (b == `CPS_MODE_CDP)));
    endfunction

    function automatic logic cps_is_cdp(input logic [2:0] m);
        return (m == `CPS_MODE_CDP) || (m == `CPS_MODE_CDP_WAKE);
    endfunction

    function automatic logic cps_is_dcp(input logic [2:0] m);
        return (m == `CPS_MODE_DCP_AUTO) || (m == `CPS_MODE_DCP_DIV) ||
            (m == `CPS_MODE_DCP_BC);
    endfunction

    cps_state_t st;
    cps_state_t next_st;
    cps_pins_t pins_in;
    logic active;
    logic en_eff;
    logic run;
    logic chg_mode;

    assign pins_in = '{en: enable_pin, mode: mode_select_pins, cur_hi: cur_above_th,
        oc: oc_detect, hot: temp_above_trip, cool: temp_cooled,
        vin_ok: vin_above_input_undervoltage_lockout, hs_done: cdp_hs_done};

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    always_comb begin
        next_st = st;
        // Pins pass two flops; only the second stage is used below
        next_st.s1 = pins_in;
        next_st.s2 = st.s1;
        en_eff = st.s2.en & ~st.soft_dis;
        active = en_eff & st.s2.vin_ok;

        // Mode tracking against the last accepted code
        if (st.s2.mode != st.mode_q) begin
            next_st.mode_q = st.s2.mode;
            next_st.cdp_ready = 1'b0;
            if (!cps_wake_pair(st.mode_q, st.s2.mode)) begin
                next_st.disch_cnt = DISCH_CYC[23:0];
            end
        end else if (st.disch_cnt != 24'h000000) begin
            next_st.disch_cnt = st.disch_cnt - 24'h000001;
        end
        // A pulse only matters while enabled and above lockout; when disabled above lockout, discharge is permanent
        if (!active) begin
            next_st.disch_cnt = 24'h000000;
        end
        run = active && (st.mode_q != `CPS_MODE_OFF) && (st.disch_cnt == 24'h000000);

        // Thermal trip with hysteresis from two comparators
        if (st.s2.hot) begin
            next_st.ot_trip = 1'b1;
        end else if (st.s2.cool) begin
            next_st.ot_trip = 1'b0;
        end

        // Overtemperature fault: set at once, released after a delay
        if (st.s2.hot) begin
            next_st.fault_ot = 1'b1;
            next_st.otr_cnt = 18'h00000;
        end else if (!st.ot_trip && st.fault_ot) begin
            if (st.otr_cnt == OT_REL_CYC[17:0] - 18'h00001) begin
                next_st.fault_ot = 1'b0;
                next_st.otr_cnt = 18'h00000;
            end else begin
                next_st.otr_cnt = st.otr_cnt + 18'h00001;
            end
        end

        // Overcurrent fault after a persistence window
        if (run && st.s2.oc) begin
            if (st.oc_cnt == OC_DGL_CYC[17:0] - 18'h00001) begin
                next_st.fault_oc = 1'b1;
            end else begin
                next_st.oc_cnt = st.oc_cnt + 18'h00001;
            end
        end else begin
            next_st.oc_cnt = 18'h00000;
            next_st.fault_oc = 1'b0;
        end

        // CDP handshake must finish while current is still low
        if (cps_is_cdp(st.mode_q) && st.s2.mode == st.mode_q && st.s2.hs_done &&
            !st.s2.cur_hi) begin
            next_st.cdp_ready = 1'b1;
        end

        // Charging flag with deglitched release
        chg_mode = run && (cps_is_cdp(st.mode_q) || cps_is_dcp(st.mode_q));
        if (!chg_mode) begin
            next_st.charging = 1'b0;
            next_st.chg_cnt = 18'h00000;
        end else if (st.s2.cur_hi && (cps_is_dcp(st.mode_q) || st.cdp_ready)) begin
            next_st.charging = 1'b1;
            next_st.chg_cnt = 18'h00000;
        end else if (st.charging) begin
            if (st.chg_cnt == CHG_DGL_CYC[17:0] - 18'h00001) begin
                next_st.charging = 1'b0;
                next_st.chg_cnt = 18'h00000;
            end else begin
                next_st.chg_cnt = st.chg_cnt + 18'h00001;
            end
        end

        // Disabled or locked out: flags cleared, handshake forgotten
        if (!active) begin
            next_st.fault_oc = 1'b0;
            next_st.fault_ot = 1'b0;
            next_st.otr_cnt = 18'h00000;
            next_st.charging = 1'b0;
            next_st.cdp_ready = 1'b0;
        end

        // Output stage; lockout leaves even discharge unpowered
        next_st.disch_on = st.s2.vin_ok && (!en_eff || st.mode_q == `CPS_MODE_OFF ||
            st.disch_cnt != 24'h000000);
        next_st.psw_on = run && !st.ot_trip;
        next_st.dsw_on = run && (st.mode_q[1] == 1'b1);
        next_st.emu_on = run;
        next_st.fault_oe = next_st.fault_oc | next_st.fault_ot;
        next_st.chg_oe = next_st.charging;

        // Wishbone slave: one-cycle ack, unmapped reads give zero
        next_st.ack = wb_cyc_i & wb_stb_i & ~st.ack;
        next_st.rdata = 32'h00000000;
        if (wb_cyc_i && wb_stb_i && !st.ack) begin
            if (wb_adr_i == `CPS_REG_CTRL) begin
                next_st.rdata[`CPS_CTRL_SOFT_DIS] = st.soft_dis;
                if (wb_we_i && wb_sel_i[0]) begin
                    next_st.soft_dis = wb_dat_i[`CPS_CTRL_SOFT_DIS];
                end
            end else if (wb_adr_i == `CPS_REG_STATUS) begin
                next_st.rdata[15:0] = {2'h0, st.mode_q, st.ot_trip, st.cdp_ready,
                    st.fault_ot, st.fault_oc, st.charging, st.emu_on, st.dsw_on,
                    st.psw_on, st.disch_on, st.s2.vin_ok, st.s2.en};
            end
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st <= '0;
            st.soft_dis <= `CPS_CTRL_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign wb_dat_o = st.rdata;
    assign wb_ack_o = st.ack;
    assign discharge_on = st.disch_on;
    assign power_switch_on = st.psw_on;
    assign data_switch_on = st.dsw_on;
    assign emulation_on = st.emu_on;
    assign fault_n_o = st.s2.hs_done & 1'b0; // Open drain: only ever pulls low
    assign fault_n_oe = st.fault_oe;
    assign charging_n_o = st.s2.hs_done & 1'b0;
    assign charging_n_oe = st.chg_oe;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cps_cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    disch_start_a: assert property (st.s2.mode != st.mode_q && st.s2.en && st.s2.vin_ok &&
        !st.soft_dis && !cps_wake_pair(st.mode_q, st.s2.mode)
        |=> st.disch_cnt == DISCH_CYC[23:0] ##1 discharge_on && !power_switch_on)
        else $error("discharge pulse not started");
    wake_skip_a: assert property (st.s2.mode != st.mode_q && st.disch_cnt == 24'h000000 &&
        cps_wake_pair(st.mode_q, st.s2.mode) |=> st.disch_cnt == 24'h000000)
        else $error("pulse started on wakeup change");
    perm_disch_a: assert property (st.s2.vin_ok && !st.s2.en |=> discharge_on)
        else $error("discharge off while disabled");
    dis_flags_a: assert property (!st.s2.en |=> !fault_n_oe && !charging_n_oe &&
        !power_switch_on && !data_switch_on && !emulation_on)
        else $error("outputs active while disabled");
    ot_trip_a: assert property (st.s2.hot && st.s2.en && st.s2.vin_ok && !st.soft_dis
        |=> fault_n_oe ##1 !power_switch_on)
        else $error("overtemperature not handled");
    oc_dgl_a: assert property ($rose(st.fault_oc) |-> $past(st.oc_cnt) ==
        OC_DGL_CYC[17:0] - 18'h00001)
        else $error("overcurrent fault too early");
    cdp_hs_a: assert property ($rose(st.charging) && $past(cps_is_cdp(st.mode_q))
        |-> $past(st.cdp_ready))
        else $error("CDP flag without handshake");
    chg_rel_a: assert property ($fell(st.charging) && $past(st.s2.en) && $past(st.s2.vin_ok)
        && $past(st.disch_cnt) == 24'h000000 && $past(st.mode_q) == st.mode_q
        |-> $past(st.chg_cnt) == CHG_DGL_CYC[17:0] - 18'h00001)
        else $error("charging released without deglitch");
    input_undervoltage_lockout_off_a: assert property (!st.s2.vin_ok |=> !power_switch_on && !discharge_on)
        else $error("active under lockout");
    wb_ack_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus ack not single cycle");

    pulse_c: cover property ($fell(st.disch_cnt != 24'h000000) ##1 power_switch_on);
    charge_c: cover property ($rose(charging_n_oe) ##[1:1000] $fell(charging_n_oe));
    fault_c: cover property ($rose(st.fault_ot) ##[1:1000] $fell(st.fault_ot));
endmodule

// ===== inc/cps_defines.svh
`ifndef CPS_DEFINES_SVH
`define CPS_DEFINES_SVH
// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define CPS_CLK_KHZ 25000
`define CPS_DISCH_PULSE_MS 350
`define CPS_OC_DGL_MS 9
`define CPS_CHG_DGL_US 1000
`define CPS_OT_REL_US 1000
// ----------------------------------------
// Mode-select codes
// ----------------------------------------
`define CPS_MODE_OFF 3'h0
`define CPS_MODE_DCP_AUTO 3'h1
`define CPS_MODE_SDP_WAKE 3'h2
`define CPS_MODE_CDP_WAKE 3'h3
`define CPS_MODE_DCP_BC 3'h4
`define CPS_MODE_DCP_DIV 3'h5
`define CPS_MODE_SDP 3'h6
`define CPS_MODE_CDP 3'h7
// ----------------------------------------
// Register map and fields
// ----------------------------------------
`define CPS_REG_CTRL 4'h0
`define CPS_REG_STATUS 4'h4
`define CPS_CTRL_SOFT_DIS 0
`define CPS_CTRL_RESET 1'b0
`endif

// ===== inc/cps_pkg.sv
package cps_pkg;
    // Synchronised pin inputs
    typedef struct packed {
        logic en;
        logic [2:0] mode;
        logic cur_hi;
        logic oc;
        logic hot;
        logic cool;
        logic vin_ok;
        logic hs_done;
    } cps_pins_t;

    // Whole block state
    typedef struct packed {
        cps_pins_t s1;
        cps_pins_t s2;
        logic [2:0] mode_q;
        logic [23:0] disch_cnt;
        logic [17:0] oc_cnt;
        logic [17:0] chg_cnt;
        logic [17:0] otr_cnt;
        logic ot_trip;
        logic fault_oc;
        logic fault_ot;
        logic cdp_ready;
        logic charging;
        logic soft_dis;
        logic disch_on;
        logic psw_on;
        logic dsw_on;
        logic emu_on;
        logic fault_oe;
        logic chg_oe;
        logic ack;
        logic [31:0] rdata;
    } cps_state_t;
endpackage

// ===== tb/cps_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Host controller and port device pins
// ----------------------------------------
module cps_host_model
    import cps_pkg::*;
(
    input wire logic sys_clk, // Bench clock
    input wire logic fault_n_oe, // Fault flag from the block
    input wire logic react, // Host reacts to a fault
    output cps_pins_t pins // Pin levels toward the block
);
    initial pins = '0;

    // Whole code moves on one edge, so no in-between code is ever seen
    task automatic drive(input cps_pins_t p);
        @(posedge sys_clk);
        pins <= p;
    endtask

    // Host answers a fault by pulling enable low
    always @(posedge sys_clk) begin
        if (react && fault_n_oe)
            pins.en <= 1'b0;
    end
endmodule

// ===== tb/tb.sv
`timescale 1ns/1ps
module tb
    import cps_pkg::*;
;
    // ----------------------------------------
    // Bench signals and the block
    // ----------------------------------------
    localparam int DC = 20;
    logic sys_clk = 0, sys_rst = 1, cyc = 0, stb = 0, we = 0, react = 0;
    logic [3:0] adr = 4'h0;
    logic [31:0] wdat = 32'h0, rd, rs = 32'h656a, wb_dat_o;
    logic wb_ack_o, discharge_on, power_switch_on, data_switch_on, emulation_on;
    logic fault_n_o, fault_n_oe, charging_n_o, charging_n_oe;
    cps_pins_t pins, p;
    int err_count = 0, compares = 0, prev, m;
    int seq[11] = '{6, 3, 7, 3, 2, 3, 1, 5, 4, 0, 7};

    cps_host_model hm (.sys_clk, .fault_n_oe, .react, .pins);
    cps_supervisor #(.DISCH_CYC(DC), .OC_DGL_CYC(8), .CHG_DGL_CYC(6), .OT_REL_CYC(5)) dut (
        .sys_clk, .sys_rst, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o, .wb_ack_o, .enable_pin(pins.en),
        .mode_select_pins(pins.mode), .cur_above_th(pins.cur_hi), .oc_detect(pins.oc),
        .temp_above_trip(pins.hot), .temp_cooled(pins.cool), .vin_above_input_undervoltage_lockout(pins.vin_ok),
        .cdp_hs_done(pins.hs_done), .discharge_on, .power_switch_on, .data_switch_on,
        .emulation_on, .fault_n_o, .fault_n_oe, .charging_n_o, .charging_n_oe);

    // 25 MHz clock
    initial begin
        forever #20 sys_clk = ~sys_clk;
    end

    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // Reference: moves between 011 and 010, 110 or 111 keep the port powered
    function automatic int pulse_of(input int a, input int b);
        return !(a == b || (a == 3 && (b == 2 || b >= 6)) || (b == 3 && (a == 2 || a >= 6)));
    endfunction

    // Sample a little after the edge so the block's flops have settled
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        #1;
        compares++;
        if (g !== e) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic go(input int n);
        hm.drive(p);
        step(n);
    endtask

    // Classic single cycle; a dead slave is caught by the watchdog alone
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] r);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge sys_clk);
        end while (wb_ack_o !== 1'b1);
        r = wb_dat_o;
        cyc <= 0;
        stb <= 0;
        step(1);
    endtask

    task automatic test_done();
        $display("Checks %0d, mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Watchdog well beyond the whole sequence
    initial begin
        repeat (4000) @(posedge sys_clk);
        err_count++;
        test_done();
    end

    // Main sequence
    initial begin
        p = '{en: 1'b1, vin_ok: 1'b1, default: '0};
        step(4);
        sys_rst <= 0;
        go(6);
        chk({discharge_on, power_switch_on}, 2);
        p.en = 0;
        p.mode = 3'h7;
        go(6);
        chk({discharge_on, power_switch_on, data_switch_on, emulation_on}, 8);
        p = '{en: 1'b1, vin_ok: 1'b1, default: '0};
        go(6);
        prev = 0;
        for (int i = 0; i < 20; i++) begin
            rs = xs(rs);
            m = (i < 11) ? seq[i] : int'(rs[2:0]);
            if ((prev | m) == 6 && (prev ^ m) == 4)
                m = 3;
            p.mode = m[2:0];
            go(6);
            chk({discharge_on, power_switch_on}, (pulse_of(prev, m) || m == 0) ? 2 : 1);
            step(DC);
            chk({discharge_on, power_switch_on, data_switch_on},
                {m == 0, m != 0, m == 2 || m == 3 || m >= 6});
            prev = m;
        end
        p.mode = 3'h5;
        go(12);
        p.mode = 3'h4;
        go(16);
        chk(discharge_on, 1);
        step(14);
        chk(discharge_on, 0);
        p.cur_hi = 1;
        go(6);
        chk({charging_n_oe, charging_n_o}, 2);
        p.cur_hi = 0;
        go(5);
        chk(charging_n_oe, 1);
        step(8);
        chk(charging_n_oe, 0);
        p.mode = 3'h7;
        go(DC + 6);
        p.cur_hi = 1;
        go(6);
        chk(charging_n_oe, 0);
        p.cur_hi = 0;
        p.hs_done = 1;
        go(12);
        p.cur_hi = 1;
        go(6);
        chk(charging_n_oe, 1);
        p.oc = 1;
        go(6);
        chk({fault_n_oe, fault_n_o}, 0);
        step(10);
        chk(fault_n_oe, 1);
        p.oc = 0;
        go(6);
        chk(fault_n_oe, 0);
        p.hot = 1;
        go(5);
        chk({fault_n_oe, power_switch_on}, 2);
        p.hot = 0;
        go(6);
        chk(power_switch_on, 0);
        p.cool = 1;
        go(6);
        chk({fault_n_oe, power_switch_on}, 3);
        step(8);
        chk(fault_n_oe, 0);
        react <= 1;
        p.cool = 0;
        p.oc = 1;
        go(20);
        chk({fault_n_oe, charging_n_oe, discharge_on, power_switch_on}, 2);
        react <= 0;
        p = '{en: 1'b1, vin_ok: 1'b0, mode: 3'h7, default: '0};
        go(DC + 8);
        chk({discharge_on, power_switch_on, data_switch_on}, 0);
        p.vin_ok = 1;
        go(DC + 8);
        wb(0, 4'h4, 0, rd);
        chk({rd[13:11], rd[1:0]}, 5'h1f);
        wb(1, 4'h0, 1, rd);
        step(6);
        chk({discharge_on, power_switch_on}, 2);
        wb(0, 4'h8, 0, rd);
        chk(rd, 0);
        wb(1, 4'h0, 0, rd);
        test_done();
    end
endmodule
